// >>> hw/pic_pkg.sv
package pic_pkg;

  // ---------------------------------------------------------------------
  // Register map.
  // ---------------------------------------------------------------------

  // Printed register offsets; each is a 16-bit register.
  localparam logic [31:0] PIC_OFF_PRIO_EXT_LO   = 32'hffff8348;
  localparam logic [31:0] PIC_OFF_PRIO_EXT_HI   = 32'hffff834a;
  localparam logic [31:0] PIC_OFF_PRIO_PERIPH_C = 32'hffff834c;
  localparam logic [31:0] PIC_OFF_PRIO_PERIPH_D = 32'hffff834e;
  localparam logic [31:0] PIC_OFF_PRIO_PERIPH_E = 32'hffff8350;
  localparam logic [31:0] PIC_OFF_PRIO_PERIPH_F = 32'hffff8352;
  localparam logic [31:0] PIC_OFF_PRIO_PERIPH_G = 32'hffff8354;
  localparam logic [31:0] PIC_OFF_PRIO_PERIPH_H = 32'hffff8356;
  localparam logic [31:0] PIC_OFF_DETECT_CONTROL = 32'hffff8358;
  localparam logic [31:0] PIC_OFF_REQUEST_STATUS = 32'hffff835a;

  // Word index on the bus: halfword distance from the first register.
  localparam logic [31:0] PIC_IDX_DIFF_CTRL =
    (PIC_OFF_DETECT_CONTROL - PIC_OFF_PRIO_EXT_LO) >> 1;
  localparam logic [31:0] PIC_IDX_DIFF_STAT =
    (PIC_OFF_REQUEST_STATUS - PIC_OFF_PRIO_EXT_LO) >> 1;
  localparam logic [3:0]  PIC_IDX_CTRL = PIC_IDX_DIFF_CTRL[3:0];
  localparam logic [3:0]  PIC_IDX_STAT = PIC_IDX_DIFF_STAT[3:0];
  localparam int          PIC_NUM_PRIO = 8;

  // Reset values.
  localparam logic [15:0] PIC_PRIO_RESET = 16'h0000;
  localparam logic [15:0] PIC_STAT_RESET = 16'h0000;

  // Field positions in the detect control register.
  localparam int PIC_CTRL_NMI_LEVEL_BIT = 15;
  localparam int PIC_CTRL_NMI_EDGE_BIT  = 8;

  // Flag and sense bit position of each external pin (pins 0,1,2,3,6,7).
  localparam int PIC_NUM_EXT = 6;
  localparam logic [3:0] PIC_EXT_BIT [PIC_NUM_EXT] =
    '{4'h7, 4'h6, 4'h5, 4'h4, 4'h1, 4'h0};

  // ---------------------------------------------------------------------
  // Sources, vectors and priority fields.
  // ---------------------------------------------------------------------

  // A field index is register * 4 + nibble, nibble 0 being bits 15:12.
  localparam logic [7:0] PIC_NMI_VECTOR = 8'h0b;
  localparam logic [4:0] PIC_NMI_LEVEL  = 5'h10;
  localparam logic [3:0] PIC_NMI_MASK   = 4'hf;
  localparam logic [7:0] PIC_EXT_VEC [PIC_NUM_EXT] =
    '{8'h40, 8'h41, 8'h42, 8'h43, 8'h46, 8'h47};
  localparam logic [4:0] PIC_EXT_FLD [PIC_NUM_EXT] =
    '{5'h00, 5'h01, 5'h02, 5'h03, 5'h06, 5'h07};

  // Peripheral lines in default ranking order, highest first.
  localparam int PIC_NUM_PER = 28;
  localparam logic [7:0] PIC_PER_VEC [PIC_NUM_PER] = '{
    8'h48, 8'h4c, 8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h60, 8'h61, 8'h64,
    8'h65, 8'h68, 8'h69, 8'h6c, 8'h6d, 8'h80, 8'h81, 8'h82, 8'h83, 8'h84,
    8'h85, 8'h86, 8'h87, 8'h88, 8'h90, 8'h94, 8'h98, 8'h99};
  localparam logic [4:0] PIC_PER_FLD [PIC_NUM_PER] = '{
    5'h08, 5'h09, 5'h0c, 5'h0c, 5'h0c, 5'h0c, 5'h0d, 5'h0e, 5'h0e, 5'h0f,
    5'h0f, 5'h10, 5'h10, 5'h11, 5'h11, 5'h16, 5'h16, 5'h16, 5'h16, 5'h17,
    5'h17, 5'h17, 5'h17, 5'h18, 5'h1a, 5'h1b, 5'h1c, 5'h1c};

  // Arbitration source numbers: NMI, then pins, then peripherals.
  localparam int PIC_NUM_SRC = 1 + PIC_NUM_EXT + PIC_NUM_PER;
  typedef logic [5:0] pic_src_t;

endpackage : pic_pkg

// >>> hw/pic_controller.sv
// ---------------------------------------------------------------------
// Prioritising interrupt controller with an Avalon-MM register slave.
// ---------------------------------------------------------------------

// Behaviour
// - Levels 0 to 16; level 0 masks source.
// - NMI level 16, always forwarded regardless of mask.
// - NMI edge only; control bit picks polarity.
// - Accepted NMI loads mask level 15.
// - Per-pin sense bit: low level or falling edge.
// - Level mode follows pin; flag shows request.
// - Edge mode latches fall until accepted.
// - Write 0 after reading 1 clears latch.
// - Accepted pin loads its priority as mask.
// - Pin priority nibbles in first two registers.
// - Distinct peripheral vectors; priorities from registers three-eight.
// - Accepted peripheral loads its priority as mask.
// - Vector 11 NMI, 64-67, 70, 71 pins.
// - Shared-field peripherals ranked in fixed order.
// - Reset sets every priority to zero.
// - Ties resolved by fixed default ranking.
// - Control reset reads 0x8000 when NMI high.
// - Status register: only zero writes clear flags.
// - Ten registers; 8, 16, 32-bit access.
module pic_controller (
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  // Avalon-MM slave, word addressed.
  input  wire logic [3:0]                   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  // Pins and peripheral request lines.
  input  wire logic                         nmi_pin,
  input  wire logic [pic_pkg::PIC_NUM_EXT-1:0] ext_request_pins_n,
  input  wire logic [pic_pkg::PIC_NUM_PER-1:0] periph_req,
  // CPU exception interface.
  input  wire logic [3:0]                   cpu_mask_level,
  input  wire logic                         cpu_accept,
  output logic                              cpu_int_req,
  output logic      [7:0]                   cpu_int_vector,
  output logic      [3:0]                   cpu_new_mask
);
  import pic_pkg::*;

  // ---------------------------------------------------------------------
  // Storage.
  // ---------------------------------------------------------------------

  // Level-mode flags are not stored: they are derived from the sampled
  // pins, so a flag can never disagree with the request it reports.
  logic [15:0]            prio_q [PIC_NUM_PRIO]; // Priority registers.
  logic                   nmi_edge_sel_q;        // 1 selects rising edge.
  logic [PIC_NUM_EXT-1:0] sense_edge_q;          // 1 selects falling edge.
  logic                   nmi_level_q;           // Sampled NMI pin.
  logic                   nmi_latch_q;           // Pending NMI.
  logic [PIC_NUM_EXT-1:0] pin_q;                 // Sampled ext pins.
  logic [PIC_NUM_EXT-1:0] edge_latch_q;          // Latched falling edges.
  logic [PIC_NUM_EXT-1:0] armed_q;               // Flag was read as 1.
  logic                   wait_q;                // Registered waitrequest.
  logic [31:0]            rdata_q;               // Registered read data.
  logic                   req_q;                 // Request to the CPU.
  logic [7:0]             vec_q;                 // Presented vector.
  logic [3:0]             mask_q;                // Mask to load on accept.
  pic_src_t               src_q;                 // Presented source.

  // ---------------------------------------------------------------------
  // Bus decode.
  // ---------------------------------------------------------------------

  // A request commits on the edge where waitrequest is already low; a
  // read is taken, and its data captured, one edge earlier.
  logic        commit_wr;
  logic        rd_taken;
  logic        hit;
  logic [15:0] wmask;
  logic [15:0] pin_flags;

  assign commit_wr = avs_write && !wait_q;
  assign rd_taken  = avs_read && wait_q;
  assign hit       = (avs_address <= PIC_IDX_STAT);
  // Byte lane 0 is the low byte of the register, lane 1 the high byte.
  assign wmask     = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // Flag view: level mode shows the sampled pin, edge mode the latch.
  always_comb begin
    pin_flags = 16'h0000;
    for (int i = 0; i < PIC_NUM_EXT; i++) begin
      pin_flags[PIC_EXT_BIT[i]] = sense_edge_q[i] ? edge_latch_q[i]
                                                  : !pin_q[i];
    end
  end

  // Read multiplexer; unmapped words read as zero.
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (avs_address < PIC_IDX_CTRL) begin
      rd_mux = prio_q[avs_address[2:0]];
    end else if (avs_address == PIC_IDX_CTRL) begin
      rd_mux[PIC_CTRL_NMI_LEVEL_BIT] = nmi_level_q;
      rd_mux[PIC_CTRL_NMI_EDGE_BIT]  = nmi_edge_sel_q;
      for (int i = 0; i < PIC_NUM_EXT; i++) begin
        rd_mux[PIC_EXT_BIT[i]] = sense_edge_q[i];
      end
    end else if (avs_address == PIC_IDX_STAT) begin
      rd_mux = pin_flags;
    end
  end

  // ---------------------------------------------------------------------
  // Bus handshake.
  // ---------------------------------------------------------------------

  // Waitrequest drops for exactly one cycle per request, one cycle after
  // the request appears, so every access takes two clock edges.
  // The fixed wait state costs one cycle per access but keeps the read
  // path registered and the master's timing the same for every register.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
    end
  end

  // Read data is captured while waitrequest is still high, so it stands
  // at the edge where the master takes it.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_taken) begin
      rdata_q <= {16'h0000, hit ? rd_mux : 16'h0000};
    end
  end

  // ---------------------------------------------------------------------
  // Register writes.
  // ---------------------------------------------------------------------

  // Priority registers; byte enables give 8, 16 and 32-bit access.
  // Lanes 2 and 3 are ignored, so a 32-bit access reaches only the
  // register at its own word index; software must allow for that.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int r = 0; r < PIC_NUM_PRIO; r++) begin
        prio_q[r] <= PIC_PRIO_RESET;
      end
    end else if (commit_wr && avs_address < PIC_IDX_CTRL) begin
      prio_q[avs_address[2:0]] <= (prio_q[avs_address[2:0]] & ~wmask)
                                | (avs_writedata[15:0] & wmask);
    end
  end

  // Detect control: edge select and sense bits; the level bit is read only.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      nmi_edge_sel_q <= 1'b0;
      sense_edge_q   <= '0;
    end else if (commit_wr && avs_address == PIC_IDX_CTRL) begin
      if (wmask[PIC_CTRL_NMI_EDGE_BIT]) begin
        nmi_edge_sel_q <= avs_writedata[PIC_CTRL_NMI_EDGE_BIT];
      end
      for (int i = 0; i < PIC_NUM_EXT; i++) begin
        if (wmask[PIC_EXT_BIT[i]]) begin
          sense_edge_q[i] <= avs_writedata[PIC_EXT_BIT[i]];
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Pin sampling and edge detection.
  // ---------------------------------------------------------------------

  // The NMI level is sampled on every edge, reset included, so the
  // control register shows the pin right after reset is released.
  always_ff @(posedge ref_clk) begin
    nmi_level_q <= nmi_pin;
  end

  // Pins idle high; resetting the samples high avoids a false edge.
  // The pins are taken as synchronous to ref_clk; an asynchronous source
  // needs a synchroniser in front of this block.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pin_q <= '1;
    end else begin
      pin_q <= ext_request_pins_n;
    end
  end

  // NMI edge in the selected direction; only edges count, never levels.
  logic nmi_edge;
  assign nmi_edge = nmi_edge_sel_q ? (nmi_pin && !nmi_level_q)
                                   : (!nmi_pin && nmi_level_q);

  // NMI latch: an edge in the accept cycle wins over the clear.
  // A second edge before acceptance is merged into the pending one.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      nmi_latch_q <= 1'b0;
    end else if (nmi_edge) begin
      nmi_latch_q <= 1'b1;
    end else if (cpu_accept && src_q == pic_src_t'(0)) begin
      nmi_latch_q <= 1'b0;
    end
  end

  // Armed bits remember a flag that software has read as 1. They are set
  // on the edge where the read data is captured, so a latch that sets
  // while the read waits cannot be armed by a read that returned 0.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      armed_q <= '0;
    end else begin
      for (int i = 0; i < PIC_NUM_EXT; i++) begin
        if (!edge_latch_q[i]) begin
          armed_q[i] <= 1'b0;
        end else if (rd_taken && avs_address == PIC_IDX_STAT
                     && avs_byteenable[0]) begin
          armed_q[i] <= 1'b1;
        end
      end
    end
  end

  // Edge latches: set on a falling edge, cleared on acceptance or by a
  // zero written to an armed flag. A new edge in the same cycle wins.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      edge_latch_q <= '0;
    end else begin
      for (int i = 0; i < PIC_NUM_EXT; i++) begin
        if (sense_edge_q[i] && pin_q[i] && !ext_request_pins_n[i]) begin
          edge_latch_q[i] <= 1'b1;
        end else if (!sense_edge_q[i]) begin
          edge_latch_q[i] <= 1'b0;
        end else if (cpu_accept && src_q == pic_src_t'(i + 1)) begin
          edge_latch_q[i] <= 1'b0;
        end else if (commit_wr && avs_address == PIC_IDX_STAT
                     && wmask[PIC_EXT_BIT[i]]
                     && !avs_writedata[PIC_EXT_BIT[i]] && armed_q[i]) begin
          edge_latch_q[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Arbitration.
  // ---------------------------------------------------------------------

  // Priority nibble for a field index.
  function automatic logic [3:0] nib(input logic [4:0] fld);
    logic [15:0] word;
    word = prio_q[fld[4:2]];
    unique case (fld[1:0])
      2'h0: nib = word[15:12];
      2'h1: nib = word[11:8];
      2'h2: nib = word[7:4];
      2'h3: nib = word[3:0];
    endcase
  endfunction

  // Scan in default ranking order and replace the winner only on a
  // strictly higher level, so the earlier source keeps every tie.
  // The scan is one long comparator chain; it is cheap in area and short
  // enough for this clock, but it grows with every source that is added.
  logic [4:0] best_lvl;
  logic [7:0] best_vec;
  pic_src_t   best_src;
  logic [4:0] lvl;
  always_comb begin
    best_lvl = 5'h00;
    best_vec = 8'h00;
    best_src = pic_src_t'(0);
    lvl      = 5'h00;
    if (nmi_latch_q) begin
      best_lvl = PIC_NMI_LEVEL;
      best_vec = PIC_NMI_VECTOR;
    end
    for (int i = 0; i < PIC_NUM_EXT; i++) begin
      lvl = {1'b0, nib(PIC_EXT_FLD[i])};
      if (pin_flags[PIC_EXT_BIT[i]] && lvl > best_lvl) begin
        best_lvl = lvl;
        best_vec = PIC_EXT_VEC[i];
        best_src = pic_src_t'(i + 1);
      end
    end
    for (int p = 0; p < PIC_NUM_PER; p++) begin
      lvl = {1'b0, nib(PIC_PER_FLD[p])};
      if (periph_req[p] && lvl > best_lvl) begin
        best_lvl = lvl;
        best_vec = PIC_PER_VEC[p];
        best_src = pic_src_t'(1 + PIC_NUM_EXT + p);
      end
    end
  end

  // Level zero never beats the empty start value, so it stays masked.
  // The NMI bypasses the mask compare because nothing may block it.
  logic fire;
  assign fire = (best_lvl != 5'h00)
             && (best_lvl > {1'b0, cpu_mask_level}
                 || best_lvl == PIC_NMI_LEVEL);

  // ---------------------------------------------------------------------
  // CPU side outputs.
  // ---------------------------------------------------------------------

  // The winner is registered; on accept the CPU uses what it saw, and
  // the request drops for a cycle so a cleared source is not re-sent.
  // The price is one cycle of extra latency from source to request.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      req_q  <= 1'b0;
      vec_q  <= 8'h00;
      mask_q <= 4'h0;
      src_q  <= pic_src_t'(0);
    end else if (cpu_accept) begin
      req_q  <= 1'b0;
    end else begin
      req_q  <= fire;
      vec_q  <= best_vec;
      src_q  <= best_src;
      mask_q <= (best_lvl == PIC_NMI_LEVEL)
                ? PIC_NMI_MASK
                : best_lvl[3:0];
    end
  end

  // Every output is a register, so the CPU and the bus see no glitches.
  assign cpu_int_req     = req_q;
  assign cpu_int_vector  = vec_q;
  assign cpu_new_mask    = mask_q;
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

endmodule // pic_controller

// >>> verification/pic_chk.sv
// ------------------------------------------
// Port checker for the interrupt controller.
// ------------------------------------------
module pic_chk (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [3:0]  cpu_mask_level,
  input wire logic        cpu_accept,
  input wire logic        cpu_int_req,
  input wire logic [7:0]  cpu_int_vector,
  input wire logic [3:0]  cpu_new_mask
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain, so clock and reset are stated once.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // A taken access is answered after exactly one wait cycle.
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered after one cycle");
  a_wait_idle: assert property (
    !avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without an access");
  a_rd_upper: assert property (
    avs_readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  // The NMI always loads the top mask.
  a_nmi_mask: assert property (
    cpu_int_req && cpu_int_vector == 8'h0b |-> cpu_new_mask == 4'hf)
    else $error("nmi mask not 15");
  // A maskable source must stand above the mask seen one edge earlier.
  a_above_mask: assert property (
    cpu_int_req && cpu_int_vector != 8'h0b
    |-> cpu_new_mask > $past(cpu_mask_level))
    else $error("request not above cpu mask");
  a_acc_drop: assert property (
    cpu_accept |=> !cpu_int_req)
    else $error("request not dropped after accept");
  // An NMI stays presented until it is accepted.
  a_nmi_hold: assert property (
    cpu_int_req && cpu_int_vector == 8'h0b && !cpu_accept
    |=> cpu_int_req && cpu_int_vector == 8'h0b)
    else $error("nmi withdrawn before accept");
  a_vec_legal: assert property (
    cpu_int_req |-> cpu_int_vector inside {8'h0b, [8'h40:8'h43],
                                          [8'h46:8'h99]})
    else $error("vector outside the table");

  // Main scenarios seen at least once.
  c_nmi: cover property (cpu_int_req && cpu_int_vector == 8'h0b);
  c_accept: cover property (cpu_accept ##1 !cpu_int_req);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule // pic_chk

bind pic_controller pic_chk u_chk (.*);

// >>> verification/pic_cpu_model.sv
// ---------------------------------------
// CPU exception side: accepts requests.
// ---------------------------------------
module pic_cpu_model (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       cpu_int_req,
  input  wire logic       acc_en,
  input  wire logic [3:0] acc_dly,
  input  wire logic [3:0] mask_in,
  output logic            cpu_accept,
  output logic [3:0]      cpu_mask_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q; // Cycles the request has waited.

  // The mask load sequence is not modelled, so the bench sets the mask.
  assign cpu_mask_level = mask_in;

  // One accept pulse per request after a chosen delay; a pulse that
  // outlived its request would steal the next one.
  always_ff @(posedge ref_clk) begin
    if (!reset_n || cpu_accept || !acc_en || cpu_int_req !== 1'h1) begin
      wait_q     <= 4'h0;
      cpu_accept <= 1'h0;
    end else if (wait_q >= acc_dly) begin
      cpu_accept <= 1'h1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // pic_cpu_model

// >>> verification/testbench.sv
// ---------------------------------------
// Self-checking bench for the controller.
// ---------------------------------------
module testbench;
  import pic_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   ref_clk = 1'h0;  // Runs at 25 MHz.
  logic                   reset_n = 1'h0;  // Held low two cycles.
  logic [3:0]             avs_address = 4'h0;
  logic                   avs_read = 1'h0;
  logic                   avs_write = 1'h0;
  logic [31:0]            avs_writedata = 32'h0;
  logic [3:0]             avs_byteenable = 4'h0;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   nmi_pin = 1'h1;
  logic [PIC_NUM_EXT-1:0] ext_request_pins_n = 6'h3f;
  logic [PIC_NUM_PER-1:0] periph_req = 28'h0;
  logic [3:0]             mask_in = 4'h0;  // Mask the CPU shows.
  logic [3:0]             acc_dly = 4'h0;  // Accept delay.
  logic                   acc_en = 1'h0;   // Lets the CPU accept.
  logic [3:0]             cpu_mask_level;
  logic                   cpu_accept;
  logic                   cpu_int_req;
  logic [7:0]             cpu_int_vector;
  logic [3:0]             cpu_new_mask;
  logic [15:0]            q;               // Last read data.
  int                     miscompares = 0;
  int                     num_checks = 0;

  always #20 ref_clk = ~ref_clk;

  pic_controller DUT (.*);
  pic_cpu_model u_cpu (.ref_clk, .reset_n, .cpu_int_req, .acc_en,
                       .acc_dly, .mask_in, .cpu_accept, .cpu_mask_level);

  task automatic chk(input string what, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // One access, held until waitrequest is sampled low; a hang is left
  // to the watchdog, since the master assumes no answer time.
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [15:0] d, input logic [3:0] be);
    avs_address    <= a;
    avs_read       <= ~wr;
    avs_write      <= wr;
    avs_writedata  <= {16'h0, d};
    avs_byteenable <= be;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'h0);
    q = avs_readdata[15:0];
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'h1, a, d, 4'h3);
  endtask
  task automatic rd(input logic [3:0] a);
    bus(1'h0, a, 16'h0, 4'h3);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Bounded wait for a request towards the CPU.
  task automatic wait_req();
    for (int i = 0; i < 20 && cpu_int_req !== 1'h1; i++) cyc(1);
  endtask

  // Reset values with the NMI pin high, then an unmapped word.
  task automatic t_reset();
    for (int i = 0; i < 11; i++) begin
      rd(i < 10 ? 4'(i) : 4'hc);
      chk("reset", q, i == 8 ? 16'h8000 : 16'h0000);
    end
  endtask

  // Each priority word keeps its own pattern; byte lanes act alone.
  task automatic t_regs();
    for (int i = 0; i < 8; i++) wr(4'(i), 16'h5a30 + 16'(i));
    for (int i = 0; i < 8; i++) begin
      rd(4'(i));
      chk("priority", q, 16'h5a30 + 16'(i));
    end
    bus(1'h1, 4'h0, 16'hc3ff, 4'h2);
    rd(4'h0);
    chk("byte write", q, 16'hc330);
    wr(4'h8, 16'h0000);
    rd(4'h8);
    chk("level bit", q, 16'h8000);
  endtask

  // Each pin latches a fall, keeps it once high, and gives its vector.
  task automatic t_pins();
    int e;
    wr(4'h0, 16'h5678);
    wr(4'h1, 16'h009a);
    wr(4'h8, 16'h00f3);
    acc_dly <= 4'h3;
    for (int k = 0; k < 6; k++) begin
      e = k < 4 ? 64 + k : 66 + k;
      ext_request_pins_n[k] <= 1'h0;
      wait_req();
      chk("vec", 16'(cpu_int_vector), 16'(e));
      chk("mask", 16'(cpu_new_mask), 16'(5 + k));
      ext_request_pins_n[k] <= 1'h1;
      cyc(3);
      chk("held", 16'(cpu_int_req), 16'h1);
      acc_en <= 1'h1;
      cyc(8);
      acc_en <= 1'h0;
      chk("accepted", 16'(cpu_int_req), 16'h0);
    end
  endtask

  // In level mode a pin requests only while it is low.
  task automatic t_level();
    wr(4'h8, 16'h0000);
    ext_request_pins_n[2] <= 1'h0;
    wait_req();
    rd(4'h9);
    chk("level flag", q, 16'h0020);
    ext_request_pins_n[2] <= 1'h1;
    cyc(3);
    rd(4'h9);
    chk("flag off", q, 16'h0000);
    chk("req off", 16'(cpu_int_req), 16'h0);
  endtask

  // A latched fall behind a high mask; ones leave it, zero clears it.
  task automatic t_clear();
    mask_in <= 4'hf;
    wr(4'h8, 16'h00f3);
    ext_request_pins_n[0] <= 1'h0;
    cyc(3);
    ext_request_pins_n[0] <= 1'h1;
    cyc(3);
    chk("masked", 16'(cpu_int_req), 16'h0);
    wr(4'h9, 16'h0000);
    rd(4'h9);
    chk("edge flag", q, 16'h0080);
    wr(4'h9, 16'hffff);
    rd(4'h9);
    chk("ones", q, 16'h0080);
    wr(4'h9, 16'h0000);
    rd(4'h9);
    chk("zero", q, 16'h0000);
  endtask

  // The NMI ignores the mask, loads 15 and takes the chosen edge.
  task automatic t_nmi();
    acc_dly <= 4'h0;
    nmi_pin <= 1'h0;
    wait_req();
    chk("nmi vec", 16'(cpu_int_vector), 16'h000b);
    chk("nmi mask", 16'(cpu_new_mask), 16'h000f);
    acc_en <= 1'h1;
    cyc(4);
    wr(4'h8, 16'h0100);
    nmi_pin <= 1'h1;
    wait_req();
    chk("rise", 16'(cpu_int_vector), 16'h000b);
    cyc(4);
    nmi_pin <= 1'h0;
    cyc(4);
    chk("fall ignored", 16'(cpu_int_req), 16'h0);
    rd(4'h8);
    chk("control", q, 16'h0100);
    acc_en <= 1'h0;
  endtask

  // Shared-field order, ties by vector, masking by level and mask.
  task automatic t_periph();
    mask_in <= 4'h0;
    wr(4'h3, 16'h3000);
    periph_req <= 28'h000003c;
    for (int j = 0; j < 4; j++) begin
      cyc(3);
      chk("order", 16'(cpu_int_vector), 16'(88 + j));
      chk("pmask", 16'(cpu_new_mask), 16'h3);
      periph_req[2 + j] <= 1'h0;
    end
    wr(4'h0, 16'h3000);
    wr(4'h2, 16'h3000);
    ext_request_pins_n[0] <= 1'h0;
    periph_req[0] <= 1'h1;
    cyc(3);
    chk("tie", 16'(cpu_int_vector), 16'h0040);
    wr(4'h2, 16'h4000);
    cyc(2);
    chk("higher", 16'(cpu_int_vector), 16'h0048);
    chk("pmask", 16'(cpu_new_mask), 16'h4);
    mask_in <= 4'h4;
    cyc(3);
    chk("equal mask", 16'(cpu_int_req), 16'h0);
    mask_in <= 4'h0;
    wr(4'h2, 16'h0000);
    ext_request_pins_n[0] <= 1'h1;
    cyc(3);
    chk("level zero", 16'(cpu_int_req), 16'h0);
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence: reset for two cycles, then each scenario.
  initial begin
    cyc(2);
    reset_n <= 1'h1;
    cyc(1);
    t_reset();
    t_regs();
    t_pins();
    t_level();
    t_clear();
    t_nmi();
    t_periph();
    print_verdict();
  end

  // The scenarios need well under a thousand cycles; a hang ends here.
  initial begin
    cyc(20000);
    miscompares++;
    print_verdict();
  end
endmodule // testbench
